// [design/amg_aux_mix_regs.sv]
// apb register bank for the auxiliary 1 and auxiliary 2 mix controls
// assumes an apb master on the same clock and asynchronous pins
// What this block does
// - mute bit 0 passes the aux channel into the mix, 1 silences it
// - gain codes step 1.5 dB: 0 is +12 dB, 8 unity, 31 -34.5 dB
// - after reset the aux 1 register reads 8888 hex
// - reset or power-down pin low forces defaults and drops writes
// - all-conversions-disable at 1 holds defaults and drops writes
// - analog channel power enable at 0 holds defaults, drops writes
// - analog input mix enable at 0 holds defaults, drops writes
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module amg_aux_mix_regs
  import amg_pkg::*;
(
  // clock, reset, clock enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [amg_pkg::AMG_ADDR_W-1:0] paddr,
  input wire logic [amg_pkg::AMG_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [amg_pkg::AMG_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  input wire logic reset_pin_n,
  input wire logic power_down_pin_n,
  // auxiliary 1 toward the first dac
  output logic left_aux1_pass,
  output logic signed [amg_pkg::AMG_LEVEL_W-1:0] left_aux1_level,
  output logic right_aux1_pass,
  output logic signed [amg_pkg::AMG_LEVEL_W-1:0] right_aux1_level,
  // auxiliary 2 toward the mixer
  output logic left_aux2_pass,
  output logic signed [amg_pkg::AMG_LEVEL_W-1:0] left_aux2_level,
  output logic right_aux2_pass,
  output logic signed [amg_pkg::AMG_LEVEL_W-1:0] right_aux2_level
);
  import amg_pkg::*;

  amg_reg_if aux1_if ();
  amg_reg_if aux2_if ();

  logic [1:0] reset_pin_sync_q;
  logic [1:0] pdn_pin_sync_q;
  logic [AMG_PWR_W-1:0] pwr_q;
  logic pready_q;
  logic pslverr_q;
  logic [AMG_DATA_W-1:0] prdata_q;

  // pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reset_pin_sync_q <= 2'h0;
      pdn_pin_sync_q <= 2'h0;
    end
    else if (ce)
    begin
      reset_pin_sync_q <= {reset_pin_sync_q[0], reset_pin_n};
      pdn_pin_sync_q <= {pdn_pin_sync_q[0], power_down_pin_n};
    end
  end

  wire reset_pin_low = ~reset_pin_sync_q[1];
  wire pdn_pin_low = ~pdn_pin_sync_q[1];
  wire all_conversions_disable = pwr_q[AMG_PWR_CONVDIS_BIT];
  wire analog_channels_power_enable = pwr_q[AMG_PWR_ANALOG_CHANNELS_POWER_ENABLE_BIT];
  wire analog_input_mix_enable = pwr_q[AMG_PWR_MIXEN_BIT];

  wire mix_hold = reset_pin_low | pdn_pin_low
                | all_conversions_disable
                | ~analog_channels_power_enable
                | ~analog_input_mix_enable;

  // address decode
  wire hit_aux1 = paddr == amg_byte_addr(AMG_IDX_AUX1);
  wire hit_aux2 = paddr == amg_byte_addr(AMG_IDX_AUX2);
  wire hit_pwr = paddr == amg_byte_addr(AMG_IDX_PWR);
  wire hit_any = hit_aux1 | hit_aux2 | hit_pwr;
  wire setup = psel & ~penable;
  wire commit = psel & penable & pready_q;
  wire wr_ok = commit & pwrite & ~pslverr_q;

  // byte lanes merge into the old value; reserved bits always store zero
  function automatic logic [AMG_REG_W-1:0] merge_lanes(
    input logic [AMG_REG_W-1:0] old_value,
    input logic [AMG_REG_W-1:0] new_value,
    input logic [AMG_REG_W-1:0] mask
  );
    merge_lanes = ((new_value & mask) | (old_value & ~mask)) & AMG_MIX_WMASK;
  endfunction : merge_lanes

  wire [AMG_REG_W-1:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [AMG_REG_W-1:0] wdata16 = pwdata[AMG_REG_W-1:0];
  wire [AMG_REG_W-1:0] aux1_new =
    merge_lanes(aux1_if.value, wdata16, lane_mask);
  wire [AMG_REG_W-1:0] aux2_new =
    merge_lanes(aux2_if.value, wdata16, lane_mask);

  assign aux1_if.wr = wr_ok & hit_aux1;
  assign aux1_if.wdata = aux1_new;
  assign aux1_if.hold = mix_hold;
  assign aux2_if.wr = wr_ok & hit_aux2;
  assign aux2_if.wdata = aux2_new;
  assign aux2_if.hold = mix_hold;

  wire pwr_wr = wr_ok & hit_pwr & pstrb[0];

  // read mux: unused upper bits read as zero
  wire [AMG_DATA_W-1:0] rd_mux =
    hit_aux1 ? {16'h0000, aux1_if.value} :
    hit_aux2 ? {16'h0000, aux2_if.value} :
    hit_pwr ? {29'h0000000, pwr_q} : 32'h00000000;

  always_ff @(posedge clock)
  begin
    if (rst)
      pwr_q <= AMG_PWR_RESET;
    else if (ce && pwr_wr)
      pwr_q <= pwdata[AMG_PWR_W-1:0];
  end

  // one wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else if (ce)
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      if (setup)
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  amg_mix_reg u_aux1 (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .bus(aux1_if.store),
    .left_pass(left_aux1_pass),
    .left_level(left_aux1_level),
    .right_pass(right_aux1_pass),
    .right_level(right_aux1_level)
  );

  amg_mix_reg u_aux2 (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .bus(aux2_if.store),
    .left_pass(left_aux2_pass),
    .left_level(left_aux2_level),
    .right_pass(right_aux2_pass),
    .right_level(right_aux2_level)
  );
endmodule : amg_aux_mix_regs

// [design/amg_pkg.sv]
// constants for the auxiliary mix gain register bank
// assumes a 32-bit apb slave with a 12-bit byte address
package amg_pkg;
  localparam int unsigned AMG_ADDR_W = 12;
  localparam int unsigned AMG_DATA_W = 32;
  localparam int unsigned AMG_REG_W = 16;
  localparam int unsigned AMG_GAIN_W = 5;
  localparam int unsigned AMG_LEVEL_W = 8;
  localparam int unsigned AMG_PWR_W = 3;
  // register indices; byte address is four times the index
  localparam logic [AMG_ADDR_W-1:0] AMG_IDX_AUX1 = 12'h004;
  localparam logic [AMG_ADDR_W-1:0] AMG_IDX_AUX2 = 12'h005;
  localparam logic [AMG_ADDR_W-1:0] AMG_IDX_PWR = 12'h020;
  // mix register layout
  localparam logic [AMG_REG_W-1:0] AMG_MIX_DEFAULT = 16'h8888;
  localparam logic [AMG_REG_W-1:0] AMG_MIX_WMASK = 16'h9f9f;
  localparam int unsigned AMG_LMUTE_BIT = 15;
  localparam int unsigned AMG_LGAIN_LSB = 8;
  localparam int unsigned AMG_RMUTE_BIT = 7;
  localparam int unsigned AMG_RGAIN_LSB = 0;
  // power control register layout
  localparam int unsigned AMG_PWR_CONVDIS_BIT = 0;
  localparam int unsigned AMG_PWR_ANALOG_CHANNELS_POWER_ENABLE_BIT = 1;
  localparam int unsigned AMG_PWR_MIXEN_BIT = 2;
  localparam logic [AMG_PWR_W-1:0] AMG_PWR_RESET = 3'h6;
  // gain level in half-dB units: code 0 is +12 dB, each code -1.5 dB
  localparam logic signed [AMG_LEVEL_W-1:0] AMG_LEVEL_TOP = 8'sh18;
  localparam logic signed [AMG_LEVEL_W-1:0] AMG_LEVEL_STEP = 8'sh03;

  function automatic logic [AMG_ADDR_W-1:0] amg_byte_addr(
    input logic [AMG_ADDR_W-1:0] idx
  );
    amg_byte_addr = {idx[AMG_ADDR_W-3:0], 2'h0};
  endfunction : amg_byte_addr

  function automatic logic signed [AMG_LEVEL_W-1:0] amg_gain_level(
    input logic [AMG_GAIN_W-1:0] code
  );
    logic signed [AMG_LEVEL_W-1:0] c;
    c = signed'({3'h0, code});
    amg_gain_level = AMG_LEVEL_TOP - AMG_LEVEL_STEP * c;
  endfunction : amg_gain_level
endpackage : amg_pkg

// [design/amg_reg_if.sv]
// link between the register decoder and one mix register
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface amg_reg_if;
  import amg_pkg::*;
  logic wr;
  logic [AMG_REG_W-1:0] wdata;
  logic hold;
  logic [AMG_REG_W-1:0] value;
  modport ctl (output wr, output wdata, output hold, input value);
  modport store (input wr, input wdata, input hold, output value);
endinterface : amg_reg_if

// [design/amg_mix_reg.sv]
// one auxiliary mix register with its mute and gain decode
// assumes the decoder masks reserved bits and merges byte lanes
`timescale 1ns/100ps
module amg_mix_reg
  import amg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // decoder side
  amg_reg_if.store bus,
  // mix control toward the analog section
  output logic left_pass,
  output logic signed [amg_pkg::AMG_LEVEL_W-1:0] left_level,
  output logic right_pass,
  output logic signed [amg_pkg::AMG_LEVEL_W-1:0] right_level
);
  import amg_pkg::*;

  logic [AMG_REG_W-1:0] value_q;
  logic [AMG_REG_W-1:0] value_d;
  wire [AMG_GAIN_W-1:0] lgain = value_q[AMG_LGAIN_LSB +: AMG_GAIN_W];
  wire [AMG_GAIN_W-1:0] rgain = value_q[AMG_RGAIN_LSB +: AMG_GAIN_W];

  // held at default and deaf to writes while any hold term is set
  assign value_d = bus.hold ? AMG_MIX_DEFAULT :
                   bus.wr ? bus.wdata : value_q;
  assign bus.value = value_q;

  always_ff @(posedge clock)
  begin
    if (rst)
      value_q <= AMG_MIX_DEFAULT;
    else if (ce)
      value_q <= value_d;
  end

  // decode lags the register by one cycle so outputs stay flopped
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      left_pass <= 1'b0;
      right_pass <= 1'b0;
      left_level <= '0;
      right_level <= '0;
    end
    else if (ce)
    begin
      left_pass <= ~value_q[AMG_LMUTE_BIT];
      right_pass <= ~value_q[AMG_RMUTE_BIT];
      left_level <= amg_gain_level(lgain);
      right_level <= amg_gain_level(rgain);
    end
  end
endmodule : amg_mix_reg

// [tb/amg_chk_sva.sv]
// checks on the aux mix bank ports
// assumes ce tied high and one clock
`timescale 1ns/100ps
module amg_chk (
  // clock, reset, apb, pin, aux 1 left
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down_pin_n,
  input wire logic left_aux1_pass,
  input wire logic signed [7:0] left_aux1_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd_ok = pready && !pwrite && !pslverr;
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("stuck");
  a_bad_addr: assert property (pready |-> pslverr ==
    !(paddr inside {12'h010, 12'h014, 12'h080})) else $error("map");
  a_upper_zero: assert property (rd_ok |-> !prdata[31:16])
    else $error("upper");
  a_res_zero: assert property (rd_ok |-> !(prdata & 32'h6060))
    else $error("reserved");
  a_aux1_dec: assert property (rd_ok && paddr == 12'h010 |->
    left_aux1_pass == !prdata[15] && left_aux1_level == 8'sh18 -
    8'sh03 * $signed({3'h0, prdata[12:8]})) else $error("gain");
  a_pin_out: assert property ((!power_down_pin_n) [*6] |->
    !left_aux1_pass && left_aux1_level == 8'sh0) else $error("mute");
  a_pin_read: assert property ((!power_down_pin_n) [*5] ##0
    (rd_ok && paddr == 12'h010) |-> prdata == 32'h8888) else $error("dflt");
endmodule : amg_chk

// [tb/tb.sv]
// bench: integer model of the aux mix bank against the design
// assumes ce held high and whole words written
`timescale 1ns/100ps
module tb;
  logic clock = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, reset_pin_n = 1'h1, power_down_pin_n = 1'h1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h13751;
  logic pready, pslverr, er, a, b, c, d;
  logic signed [7:0] la, lb, lc, ld;
  int num_errors = 0, tests_run = 0, pwr = 6, hv[3] = '{7, 4, 2};
  int aux[2] = '{34952, 34952};
  amg_aux_mix_regs amg_aux_mix_regs_i (.clock, .rst, .ce(1'h1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .reset_pin_n, .power_down_pin_n, .left_aux1_pass(a),
    .left_aux1_level(la), .right_aux1_pass(b), .right_aux1_level(lb),
    .left_aux2_pass(c), .left_aux2_level(lc), .right_aux2_pass(d),
    .right_aux2_level(ld));
  initial forever #20 clock = ~clock;
  initial #80000 report_and_stop(1'h1);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] dec(int r);
    dec = {14'h0, !r[15], !r[7], 8'(24 - 3 * r[12:8]), 8'(24 - 3 * r[4:0])};
  endfunction : dec
  task automatic chk(logic [31:0] g, e);
    tests_run++;
    num_errors += int'(g !== e);
    if (g !== e) $display("BAD %0t got %h exp %h", $time, g, e);
  endtask : chk
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] v);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, ad, v};
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    {er, rd} = {pslverr, prdata};
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic rdall;
    repeat (2) @(posedge clock);
    if (pwr != 6 || !reset_pin_n || !power_down_pin_n)
      aux = '{34952, 34952};
    chk({14'h0, a, b, la, lb}, dec(aux[0]));
    chk({14'h0, c, d, lc, ld}, dec(aux[1]));
    apb(1'h0, 12'h010, 32'h0);
    chk(rd, aux[0]);
    apb(1'h0, 12'h014, 32'h0);
    chk(rd, aux[1]);
    $display("step ok %0t", $time);
  endtask : rdall
  task automatic wr(int i, logic [15:0] v);
    repeat (4) @(posedge clock);
    apb(1'h1, 12'h010 + 12'(4 * i), {16'h0, v});
    if (pwr == 6 && reset_pin_n && power_down_pin_n)
      aux[i] = v;
    rdall;
  endtask : wr
  task automatic report_and_stop(bit to);
    num_errors += int'(to);
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    rdall;
    apb(1'h0, 12'hff0, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    wr(0, 16'h0000);
    wr(1, 16'h1f1f);
    repeat (10)
    begin
      lf = lfsr(lf);
      wr(int'(lf[16]), lf[15:0] & 16'h9f9f);
    end
    foreach (hv[k])
    begin
      pwr = hv[k];
      apb(1'h1, 12'h080, pwr);
      apb(1'h0, 12'h080, 32'h0);
      chk(rd, pwr);
      wr(k % 2, 16'h0b0c);
      pwr = 6;
      apb(1'h1, 12'h080, pwr);
      wr(k % 2, 16'h0506);
    end
    power_down_pin_n <= 1'h0;
    wr(1, 16'h0304);
    {reset_pin_n, power_down_pin_n} <= 2'h1;
    wr(0, 16'h0304);
    reset_pin_n <= 1'h1;
    wr(0, 16'h1807);
    report_and_stop(1'h0);
  end
endmodule : tb
bind amg_aux_mix_regs amg_chk amg_chk_i (.clock, .rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .power_down_pin_n,
  .left_aux1_pass, .left_aux1_level);
